// ### rtl/srtp_pkg.sv
/*
  Shared constants and carrier types for the serial transceiver reset and
  transmit pin control block.
  Assumes one reference clock domain; all timing is counted in its cycles.
*/
package srtp_pkg;
  localparam int unsigned DataWidth     = 18;
  localparam int unsigned FrameWidth    = 20;
  localparam int unsigned ClockPeriodNs = 100;
  // Power-on reset must end strictly before this time
  localparam int unsigned PorLimitNs    = 1000000;
  localparam int unsigned PorCycles     = PorLimitNs / ClockPeriodNs - 1;
  localparam logic        StartBit      = 1'h1;
  localparam logic        StopBit       = 1'h0;
  localparam int unsigned LockHits      = 4;
  localparam int unsigned LockMisses    = 4;
  localparam logic [4:0]  PosReset      = 5'h00;
  localparam logic [1:0]  CountReset    = 2'h0;

  typedef enum logic [0:0] {
    SRTP_SEARCH = 1'b0,
    SRTP_LOCKED = 1'b1
  } srtp_align_e;

  typedef struct packed {
    logic                  oe;
    logic [DataWidth-1:0]  data;
  } srtp_rxbus_s;

  typedef struct packed {
    logic                  oe;
    logic [FrameWidth-1:0] pos;
    logic [FrameWidth-1:0] neg;
  } srtp_txpair_s;
endpackage

// ### rtl/srtp_core.sv
/*
  Reset sequencing, transmit framing and pin enables, loopback path and
  frame alignment of the serial transceiver. Each reference clock cycle
  carries one 20-bit frame, presented as a word on the serial ports.
  Assumes the reference clock runs without gaps and that enable, loopback
  and the serial input arrive asynchronously.
*/
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Internal power-on reset count, started by the rst input.
// - During reset: receive bus tri-stated, word clock low.
// - Reset length counted in clocks, under 1 ms.
// - Loopback high tri-states serial output pair.
// - One 20-bit NRZ frame per reference cycle.
// - Transmit word captured every rising clock edge while rst is low.
// - Loopback routes transmit stream to own receiver.
// - Enable low tri-states transmit and receive bus.
// - Frame is start, 18 data, stop bits.
module srtp_core #(
  parameter int unsigned PorCycles = srtp_pkg::PorCycles
) (
  input  wire logic                                clock,
  input  wire logic                                rst,
  input  wire logic                                enable,
  input  wire logic                                loopbackEnable,
  input  wire logic [srtp_pkg::DataWidth-1:0]      txData,
  input  wire logic [srtp_pkg::FrameWidth-1:0]     serialIn,
  output var  srtp_pkg::srtp_txpair_s              serialOut,
  output var  srtp_pkg::srtp_rxbus_s               rxBus,
  output var  logic                                rxWordClock,
  output var  logic                                lockIndicatorN
);
  localparam int unsigned DW = srtp_pkg::DataWidth;
  localparam int unsigned FW = srtp_pkg::FrameWidth;

  function automatic logic [FW-1:0] mkFrame(input logic [DW-1:0] d);
    mkFrame = {srtp_pkg::StopBit, d, srtp_pkg::StartBit};
  endfunction

  function automatic logic [FW-1:0] winAt(input logic [2*FW-1:0] w, input logic [4:0] p);
    winAt = w[p +: FW];
  endfunction

  logic                  porActive_q;
  logic [31:0]           porCount_q;
  logic                  enSync1_q, enSync2_q;
  logic                  lbSync1_q, lbSync2_q;
  logic [FW-1:0]         inSync1_q, inSync2_q;
  logic [FW-1:0]         prevFrame_q;
  logic [4:0]            pos_q;
  logic [1:0]            hits_q, misses_q;
  srtp_pkg::srtp_align_e state_q;
  srtp_pkg::srtp_txpair_s txOut_q;
  srtp_pkg::srtp_rxbus_s  rxOut_q;
  logic                  rxClk_q;
  logic                  lockN_q;

  wire logic [FW-1:0]   rxFrame   = lbSync2_q ? txOut_q.pos : inSync2_q;
  wire logic [FW-1:0]   cand      = winAt({rxFrame, prevFrame_q}, pos_q);
  wire logic            match     = cand[0] == srtp_pkg::StartBit
                                    && cand[FW-1] == srtp_pkg::StopBit;
  wire logic [4:0]      posNext   = (pos_q == 5'(FW - 1)) ? srtp_pkg::PosReset : pos_q + 5'h01;
  wire logic            lockHit   = state_q == srtp_pkg::SRTP_SEARCH && match
                                    && hits_q == 2'(srtp_pkg::LockHits - 1);
  wire logic            lockLoss  = state_q == srtp_pkg::SRTP_LOCKED && !match
                                    && misses_q == 2'(srtp_pkg::LockMisses - 1);
  wire logic            rxLive    = !porActive_q && enSync2_q && state_q == srtp_pkg::SRTP_LOCKED;

  // Power-on reset counter, started and cleared when rst is high
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      porActive_q <= 1'b1;
      porCount_q  <= 32'h0000_0000;
    end
    else if (porActive_q)
    begin
      porCount_q  <= porCount_q + 32'h0000_0001;
      porActive_q <= porCount_q < 32'(PorCycles - 1);
    end
  end

  always_ff @(posedge clock)
  begin
    enSync1_q <= enable;
    enSync2_q <= enSync1_q;
    lbSync1_q <= loopbackEnable;
    lbSync2_q <= lbSync1_q;
    inSync1_q <= serialIn;
    inSync2_q <= inSync1_q;
    prevFrame_q <= rxFrame;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      txOut_q <= '0;
    else
    begin
      txOut_q.pos <= mkFrame(txData);
      txOut_q.neg <= ~mkFrame(txData);
      txOut_q.oe  <= enSync2_q && !lbSync2_q;
    end
  end

  // Frame aligner
  always_ff @(posedge clock)
  begin
    if (rst || porActive_q)
    begin
      state_q  <= srtp_pkg::SRTP_SEARCH;
      pos_q    <= srtp_pkg::PosReset;
      hits_q   <= srtp_pkg::CountReset;
      misses_q <= srtp_pkg::CountReset;
    end
    else
    begin
      case (state_q)
        srtp_pkg::SRTP_SEARCH:
        begin
          misses_q <= srtp_pkg::CountReset;
          if (lockHit)
          begin
            state_q <= srtp_pkg::SRTP_LOCKED;
            hits_q  <= srtp_pkg::CountReset;
          end
          else if (match)
            hits_q <= hits_q + 2'h1;
          else
          begin
            hits_q <= srtp_pkg::CountReset;
            pos_q  <= posNext;
          end
        end
        srtp_pkg::SRTP_LOCKED:
        begin
          if (lockLoss)
          begin
            state_q  <= srtp_pkg::SRTP_SEARCH;
            misses_q <= srtp_pkg::CountReset;
            pos_q    <= posNext;
          end
          else if (match)
            misses_q <= srtp_pkg::CountReset;
          else
            misses_q <= misses_q + 2'h1;
        end
        default:
          state_q <= srtp_pkg::SRTP_SEARCH;
      endcase
    end
  end

  // Receive outputs
  always_ff @(posedge clock)
  begin
    if (rst || porActive_q)
    begin
      rxOut_q <= '0;
      rxClk_q <= 1'b0;
      lockN_q <= 1'b1;
    end
    else
    begin
      rxOut_q.oe <= rxLive;
      if (rxLive)
        rxOut_q.data <= cand[FW-2:1];
      rxClk_q <= rxLive ? ~rxClk_q : 1'b0;
      lockN_q <= state_q != srtp_pkg::SRTP_LOCKED;
    end
  end

  assign serialOut      = txOut_q;
  assign rxBus          = rxOut_q;
  assign rxWordClock    = rxClk_q;
  assign lockIndicatorN = lockN_q;

  // Checks
  logic [31:0] sinceRst_q;
  always_ff @(posedge clock)
  begin
    if (rst)
      sinceRst_q <= 32'h0000_0000;
    else if (sinceRst_q != 32'hFFFF_FFFF)
      sinceRst_q <= sinceRst_q + 32'h0000_0001;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_porStarts;
    $past(rst) |-> porActive_q;
  endproperty
  a_porStarts: assert property (p_porStarts) else $error("por not started");

  property p_porHoldsRx;
    porActive_q |=> !rxBus.oe && !rxWordClock;
  endproperty
  a_porHoldsRx: assert property (p_porHoldsRx) else $error("rx active in por");

  property p_porEnds;
    (sinceRst_q >= 32'(PorCycles)) |-> !porActive_q;
  endproperty
  a_porEnds: assert property (p_porEnds) else $error("por too long");

  property p_loopTristate;
    lbSync2_q |=> !serialOut.oe;
  endproperty
  a_loopTristate: assert property (p_loopTristate) else $error("tx driven in loop");

  // Antecedent on sampled reset: release by the bench at an edge must not count
  property p_frameRate;
    !rst |=> serialOut.pos[FW-2:1] == $past(txData) && serialOut.neg == ~serialOut.pos;
  endproperty
  a_frameRate: assert property (p_frameRate) else $error("frame mismatch");

  // Looped word at boundary zero reappears on the receive bus three edges on
  property p_loopRoute;
    rxLive && $past(lbSync2_q) && pos_q == srtp_pkg::PosReset |=> rxBus.data == $past(txData, 3);
  endproperty
  a_loopRoute: assert property (p_loopRoute) else $error("loop path broken");

  property p_powerDown;
    !enSync2_q |=> !serialOut.oe ##0 !rxBus.oe;
  endproperty
  a_powerDown: assert property (p_powerDown) else $error("pins driven when off");

  property p_frameBits;
    !rst |=> serialOut.pos[0] == srtp_pkg::StartBit && serialOut.pos[FW-1] == srtp_pkg::StopBit;
  endproperty
  a_frameBits: assert property (p_frameBits) else $error("bad frame bits");

  property p_porNoLock;
    porActive_q |=> lockIndicatorN && state_q == srtp_pkg::SRTP_SEARCH;
  endproperty
  a_porNoLock: assert property (p_porNoLock) else $error("lock during por");

  c_porDone: cover property ($fell(porActive_q));
  c_locked: cover property (!porActive_q && $fell(lockIndicatorN));
  c_loopLock: cover property (lbSync2_q && rxBus.oe);
  c_lockLost: cover property ($rose(lockIndicatorN) && !porActive_q);
endmodule
`default_nettype wire

// ### verif/srtp_far_end.sv
/*
  Far-end transmitter model: sends one framed word per reference cycle,
  with the bit stream optionally delayed by a number of bit times.
  Assumes the bench supplies the reference clock and the word to send.
*/
`timescale 1ns/1ns
`default_nettype none
module srtp_far_end (
  input  wire logic                            clock,
  input  wire logic [srtp_pkg::DataWidth-1:0]  farData,
  input  wire logic [4:0]                      slip,
  output var  logic [srtp_pkg::FrameWidth-1:0] serialIn
);
  logic [srtp_pkg::FrameWidth-1:0]         lastFrame;
  wire  logic [srtp_pkg::FrameWidth-1:0]   nowFrame = {srtp_pkg::StopBit, farData,
                                                       srtp_pkg::StartBit};
  wire  logic [2*srtp_pkg::FrameWidth-1:0] stream   = {nowFrame, lastFrame};
  wire  logic [5:0]                        base     = 6'(srtp_pkg::FrameWidth) - {1'h0, slip};

  // Start in bit slip, stop in bit slip+19 of two words in a row
  always_ff @(posedge clock)
  begin
    lastFrame <= nowFrame;
    serialIn  <= stream[base +: srtp_pkg::FrameWidth];
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/*
  Self-checking bench for srtp_core with a far-end model.
  Assumes the power-on count is shortened to 20 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                    clock = 1'h0;
  logic                    rst = 1'h1;
  logic                    enable = 1'h1;
  logic                    loopbackEnable = 1'h1;
  logic [17:0]             txData = 18'h00000;
  logic [17:0]             farData = 18'h00000;
  logic [17:0]             d;
  logic [17:0]             prevD;
  logic                    r;
  logic [4:0]              slip = 5'h00;
  wire  logic [19:0]       serialIn;
  srtp_pkg::srtp_txpair_s  serialOut;
  srtp_pkg::srtp_rxbus_s   rxBus;
  logic                    rxWordClock;
  logic                    lockIndicatorN;
  int                      n_mismatch = 0;
  int                      samples_checked = 0;

  srtp_core #(.PorCycles(20)) dut (.clock(clock), .rst(rst), .enable(enable),
    .loopbackEnable(loopbackEnable), .txData(txData), .serialIn(serialIn),
    .serialOut(serialOut), .rxBus(rxBus), .rxWordClock(rxWordClock),
    .lockIndicatorN(lockIndicatorN));
  srtp_far_end farEnd (.clock(clock), .farData(farData), .slip(slip), .serialIn(serialIn));

  initial
  begin
    forever #50 clock = ~clock;
  end

  function automatic logic [19:0] frame(input logic [17:0] v);
    return {1'h0, v, 1'h1};
  endfunction

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Receive side held off while the power-on count runs
  task automatic porCheck;
    for (int i = 0; i < 20; i++)
    begin
      @(negedge clock);
      chk({rxBus.oe, rxWordClock, lockIndicatorN}, 3'h1);
    end
  endtask

  task automatic waitRx(input logic [17:0] v);
    for (int k = 0; k < 60 && (lockIndicatorN !== 1'h0 || rxBus.data !== v); k++)
      @(negedge clock);
    chk({lockIndicatorN, rxBus.oe, rxBus.data}, {2'h1, v});
  endtask

  initial
  begin
    repeat (2000) @(posedge clock);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  initial
  begin
    void'($urandom(32'hD9BD));
    d = 18'($urandom());
    txData <= d;
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    porCheck();
    waitRx(d);
    chk(serialOut.oe, 1'h0);
    r = rxWordClock;
    @(negedge clock);
    chk(rxWordClock, !r);
    $display("test por_loopback done");
    @(posedge clock);
    loopbackEnable <= 1'h0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clock);
      prevD = txData;
      txData <= (i == 0) ? 18'h00000 : (i == 1) ? 18'h3FFFF : 18'($urandom());
      @(negedge clock);
      chk({serialOut.oe, serialOut.pos, serialOut.neg},
          {1'h1, frame(prevD), ~frame(prevD)});
    end
    $display("test framing done");
    d = 18'($urandom());
    farData <= d;
    waitRx(d);
    $display("test far_end_receive done");
    // All-ones data leaves one start/stop boundary; a slip forces a hunt
    @(posedge clock);
    farData <= 18'h3FFFF;
    slip <= 5'h05;
    for (int k = 0; k < 40 && lockIndicatorN !== 1'h1; k++)
      @(negedge clock);
    chk({lockIndicatorN, rxBus.oe, rxWordClock}, 3'h4);
    waitRx(18'h3FFFF);
    $display("test slip_relock done");
    @(posedge clock);
    enable <= 1'h0;
    repeat (4) @(negedge clock);
    chk({serialOut.oe, rxBus.oe}, 2'h0);
    @(posedge clock);
    enable <= 1'h1;
    loopbackEnable <= 1'h1;
    repeat (4) @(negedge clock);
    chk(serialOut.oe, 1'h0);
    $display("test power_down done");
    @(posedge clock);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    porCheck();
    waitRx(txData);
    $display("test second_reset done");
    test_done();
  end
endmodule
`default_nettype wire
